// ### common/prt_pkg.sv
/*
 * Constants, field layout and types of the programmable reload timer.
 * Assumes a 40 MHz APB clock and a low-speed oscillator of 32.768 kHz.
 */
package prt_pkg;

    // Clock figures
    localparam int CLK_HZ = 40_000_000;
    localparam int LS_FREQ_HZ = 32_768;
    localparam int HS_FREQ_HZ = 4_000_000;
    localparam int LS_HALF_CYCLES = CLK_HZ / (2 * LS_FREQ_HZ);
    localparam int HS_HALF_CYCLES = CLK_HZ / (2 * HS_FREQ_HZ);
    localparam real HIGH_NIBBLE_WINDOW_MS = 0.73;
    localparam real HS_SETTLE_MS = 5.0;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] RELOAD0_OFFSET = 8'h04;
    localparam logic [7:0] RELOAD1_OFFSET = 8'h08;
    localparam logic [7:0] COUNT0_LOW_OFFSET = 8'h0c;
    localparam logic [7:0] COUNT0_HIGH_OFFSET = 8'h10;
    localparam logic [7:0] COUNT1_LOW_OFFSET = 8'h14;
    localparam logic [7:0] COUNT1_HIGH_OFFSET = 8'h18;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // Prescale masks for high-speed divide by 1, 4, 32
    localparam logic [4:0] PRE_DIV1 = 5'h00;
    localparam logic [4:0] PRE_DIV4 = 5'h03;
    localparam logic [4:0] PRE_DIV32 = 5'h1f;

    // Clock source codes
    typedef enum logic [1:0] {
        SRC_LOW = 2'h0,
        SRC_HS1 = 2'h1,
        SRC_HS4 = 2'h2,
        SRC_HS32 = 2'h3
    } clk_src_type;

    // Control register layout, bit 7 downward
    typedef struct packed {
        clk_src_type clk_src;    // [7:6]
        logic hs_osc_enable;     // [5]
        logic timer_output_gate; // [4]
        logic event_mode;        // [3]
        logic mode16;            // [2]
        logic [1:0] chan_run_bit; // [1:0]
    } ctrl_type;

endpackage

// ### dv/prt_chk.sv
/* Port checker of the reload timer.
   Assumes binding to the timer top with its own port names. */
`timescale 1ns/10ps
`default_nettype none
module prt_chk
    import prt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Timer outputs
    input wire logic [1:0] underflow_irq,
    input wire logic high_speed_oscillator
);
    logic acc;
    logic ctrl_wr;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed access and control write
    assign acc = psel && penable && pready;
    assign ctrl_wr = acc && pwrite && paddr == CTRL_OFFSET;
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("ready missing");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
    a_err_unmapped: assert property (acc && paddr > 8'h18 |-> pslverr) else $error("no error");
    a_err_mapped: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 8'h18 |-> !pslverr)
        else $error("false error");
    a_rdata_held: assert property (acc |=> $stable(prdata)) else $error("read data moved");
    a_irq_pulse_lo: assert property (underflow_irq[0] |=> !underflow_irq[0]) else $error("irq0 long");
    a_irq_pulse_hi: assert property (underflow_irq[1] |=> !underflow_irq[1]) else $error("irq1 long");
    // Enable pin trails the control write by two edges: register, then output flop
    a_osc_follows: assert property (ctrl_wr |=> ##1 high_speed_oscillator == $past(pwdata[5], 2))
        else $error("osc enable wrong");
    a_osc_held: assert property (!ctrl_wr |=> ##1 $stable(high_speed_oscillator)) else $error("osc moved");
    // Main scenarios reached
    c_irq_lo: cover property (underflow_irq[0]);
    c_irq_hi: cover property (underflow_irq[1]);
    c_err: cover property (acc && pslverr);
endmodule
`default_nettype wire

// ### dv/tb.sv
/* Self-checking bench of the reload timer over APB.
   Assumes package, timer and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import prt_pkg::*;
    localparam int LSH = 8;
    localparam int HSH = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic event_in = 1'b1;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, timer_output_pin_signal, high_speed_oscillator;
    logic [1:0] underflow_irq;
    logic pin0;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int irq0_cnt = 0;
    int t, k;
    // Small half periods keep the run short
    programmable_reload_timer #(.LS_HALF(LSH), .HS_HALF(HSH)) programmable_reload_timer_i (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .event_in,
        .underflow_irq, .timer_output_pin_signal, .high_speed_oscillator);
    always #12.5 pclk = ~pclk;
    // Cycle count and low irq tally
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (underflow_irq[0] === 1'b1)
            irq0_cnt <= irq0_cnt + 1;
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask
    // One transfer; holds until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        cmp(nm, e, rd);
    endtask
    task automatic wait_irq(input int b);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (underflow_irq[b] !== 1'b1 && n < 2000);
        cmp("irq seen", 32'h1, 32'(n < 2000));
    endtask
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog far beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(CTRL_OFFSET, 32'h0, "ctrl reset");
        rdchk(RELOAD0_OFFSET, 32'h0, "reload0 reset");
        rdchk(COUNT1_HIGH_OFFSET, 32'h0, "count1 high reset");
        cmp("osc after reset", 32'h0, 32'(high_speed_oscillator));
        apb(1'b1, 8'h40, 32'h1);
        cmp("unmapped write err", 32'h1, 32'(err));
        rdchk(8'h40, 32'h0, "unmapped read");
        cmp("unmapped read err", 32'h1, 32'(err));
        // Fast source with oscillator off yields no edges
        apb(1'b1, RELOAD0_OFFSET, 32'h12);
        apb(1'b1, CTRL_OFFSET, 32'h41);
        repeat (40) @(posedge pclk);
        rdchk(COUNT0_LOW_OFFSET, 32'h2, "count frozen");
        apb(1'b1, CTRL_OFFSET, 32'h20);
        // Control register, then output flop: two edges
        repeat (2) @(posedge pclk);
        cmp("osc on", 32'h1, 32'(high_speed_oscillator));
        // Slow source: interval, reload, gated output
        apb(1'b1, CTRL_OFFSET, 32'h01);
        wait_irq(0);
        t = cyc;
        wait_irq(0);
        cmp("irq interval", 32'(19 * 2 * LSH), 32'(cyc - t));
        cmp("pin gated", 32'h0, 32'(timer_output_pin_signal));
        repeat (8) @(posedge pclk);
        rdchk(COUNT0_LOW_OFFSET, 32'h2, "reload low");
        rdchk(COUNT0_HIGH_OFFSET, 32'h1, "reload high");
        // Stop right after underflow: one more decrement
        wait_irq(0);
        apb(1'b1, CTRL_OFFSET, 32'h00);
        rdchk(CTRL_OFFSET, 32'h01, "run bit held");
        repeat (40) @(posedge pclk);
        rdchk(CTRL_OFFSET, 32'h00, "run bit clear");
        rdchk(COUNT0_LOW_OFFSET, 32'h1, "stop low");
        rdchk(COUNT0_HIGH_OFFSET, 32'h1, "stop high");
        // Cascaded 16-bit count
        apb(1'b1, RELOAD0_OFFSET, 32'h01);
        apb(1'b1, RELOAD1_OFFSET, 32'h01);
        k = irq0_cnt;
        apb(1'b1, CTRL_OFFSET, 32'h05);
        wait_irq(1);
        apb(1'b1, CTRL_OFFSET, 32'h04);
        cmp("no low irq", 32'(k), 32'(irq0_cnt));
        repeat (40) @(posedge pclk);
        rdchk(COUNT0_LOW_OFFSET, 32'h0, "w0 low");
        rdchk(COUNT0_HIGH_OFFSET, 32'h0, "w0 high");
        rdchk(COUNT1_LOW_OFFSET, 32'h1, "w1 low");
        rdchk(COUNT1_HIGH_OFFSET, 32'h0, "w1 high");
        // High-speed source; settle wait cut to 100 cycles, far below HS_SETTLE_MS
        apb(1'b1, CTRL_OFFSET, 32'h20);
        repeat (100) @(posedge pclk);
        apb(1'b1, RELOAD0_OFFSET, 32'h07);
        apb(1'b1, CTRL_OFFSET, 32'hb1);
        wait_irq(0);
        t = cyc;
        pin0 = timer_output_pin_signal;
        wait_irq(0);
        cmp("hs4 interval", 32'(8 * 4 * 2 * HSH), 32'(cyc - t));
        cmp("pin toggles", 32'(!pin0), 32'(timer_output_pin_signal));
        apb(1'b1, CTRL_OFFSET, 32'hf1);
        wait_irq(0);
        t = cyc;
        wait_irq(0);
        cmp("hs32 interval", 32'(8 * 32 * 2 * HSH), 32'(cyc - t));
        // Halt before reading a fast count: one more decrement, then still
        apb(1'b1, CTRL_OFFSET, 32'hf0);
        repeat (200) @(posedge pclk);
        rdchk(COUNT0_LOW_OFFSET, 32'h6, "hs stop low");
        rdchk(COUNT0_HIGH_OFFSET, 32'h0, "hs stop high");
        // Event mode waits for input edges
        apb(1'b1, CTRL_OFFSET, 32'h00);
        apb(1'b1, RELOAD0_OFFSET, 32'h05);
        apb(1'b1, CTRL_OFFSET, 32'h09);
        repeat (40) @(posedge pclk);
        rdchk(COUNT0_LOW_OFFSET, 32'h5, "event idle");
        repeat (4) begin
            event_in <= 1'b0;
            repeat (4) @(posedge pclk);
            event_in <= 1'b1;
            repeat (4) @(posedge pclk);
        end
        rdchk(COUNT0_LOW_OFFSET, 32'h2, "event count");
        end_sim();
    end
endmodule
bind programmable_reload_timer prt_chk prt_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .underflow_irq, .high_speed_oscillator);
`default_nettype wire

// ### src/programmable_reload_timer.sv
/*
 * Two-channel programmable reload timer with an APB register slave.
 * Assumes APB requests synchronous to pclk and event_in already in the pclk domain.
 */
`timescale 1ns/10ps
`default_nettype none
module programmable_reload_timer
    import prt_pkg::*;
#(
    parameter int LS_HALF = LS_HALF_CYCLES,
    parameter int HS_HALF = HS_HALF_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event counter input
    input wire logic event_in,
    // Timer outputs
    output logic [1:0] underflow_irq,
    output logic timer_output_pin_signal,
    output logic high_speed_oscillator
);

    ctrl_type ctrl;
    logic [7:0] reload [2];
    logic [7:0] count [2];
    logic [1:0] running;
    logic [1:0] reload_pend;
    logic [1:0] uf_now;
    logic [1:0] ch_fall;
    logic [11:0] ls_cnt;
    logic [11:0] hs_cnt;
    logic [4:0] pre_cnt;
    logic [4:0] pre_mask;
    logic ls_tick;
    logic hs_tick;
    logic src_tick;
    logic phase;
    logic event_prev;
    logic in_fall;
    logic in_rise;
    logic out_toggle;
    logic setup;
    logic wr_done;
    logic [31:0] next_rdata;
    logic next_err;

    assign setup = psel && !penable;
    assign wr_done = psel && penable && pready && pwrite;

    // Low-speed half-period divider, free running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_cnt <= 12'h000;
        end else if (ls_cnt == 12'(LS_HALF - 1)) begin
            ls_cnt <= 12'h000;
        end else begin
            ls_cnt <= ls_cnt + 12'h001;
        end
    end
    assign ls_tick = (ls_cnt == 12'(LS_HALF - 1));

    // High-speed divider only runs while the oscillator is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_cnt <= 12'h000;
        end else if (!ctrl.hs_osc_enable || hs_cnt == 12'(HS_HALF - 1)) begin
            hs_cnt <= 12'h000;
        end else begin
            hs_cnt <= hs_cnt + 12'h001;
        end
    end
    assign hs_tick = ctrl.hs_osc_enable && (hs_cnt == 12'(HS_HALF - 1));

    // Prescaler on high-speed half periods
    always_comb begin
        case (ctrl.clk_src)
            SRC_HS4: pre_mask = PRE_DIV4;
            SRC_HS32: pre_mask = PRE_DIV32;
            default: pre_mask = PRE_DIV1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= 5'h00;
        end else if (hs_tick) begin
            pre_cnt <= (pre_cnt & pre_mask) == pre_mask ? 5'h00 : pre_cnt + 5'h01;
        end
    end

    always_comb begin
        if (ctrl.clk_src == SRC_LOW) begin
            src_tick = ls_tick;
        end else begin
            src_tick = hs_tick && ((pre_cnt & pre_mask) == pre_mask);
        end
    end

    // Input clock phase; event mode follows the pin instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 1'b0;
            event_prev <= 1'b0;
        end else begin
            event_prev <= event_in;
            if (src_tick) begin
                phase <= !phase;
            end
        end
    end

    always_comb begin
        if (ctrl.event_mode) begin
            in_fall = event_prev && !event_in;
            in_rise = !event_prev && event_in;
        end else begin
            in_fall = src_tick && phase;
            in_rise = src_tick && !phase;
        end
    end

    // Per-channel down counters; channel 1 chains on channel 0 in 16-bit mode
    generate
        for (genvar i = 0; i < 2; i++) begin : g_chan
            logic active;
            logic [7:0] wr_reload_offset;

            assign wr_reload_offset = (i == 0) ? RELOAD0_OFFSET : RELOAD1_OFFSET;
            if (i == 0) begin : g_clk0
                assign ch_fall[i] = in_fall;
                assign active = running[0];
            end else begin : g_clk1
                assign ch_fall[i] = ctrl.mode16 ? uf_now[0] : in_fall;
                assign active = ctrl.mode16 ? 1'b1 : running[1];
            end
            assign uf_now[i] = ch_fall[i] && active && (count[i] == 8'h00);

            // Run state only changes on an input falling edge
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    running[i] <= 1'b0;
                end else if (in_fall) begin
                    running[i] <= ctrl.chan_run_bit[i];
                end
            end

            // Decrement, underflow and reload settling
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    count[i] <= COUNT_RESET;
                    reload_pend[i] <= 1'b0;
                end else if (wr_done && paddr == wr_reload_offset && !active) begin
                    count[i] <= pwdata[7:0];
                end else if (ch_fall[i] && active) begin
                    count[i] <= count[i] - 8'h01;
                    if (count[i] == 8'h00) begin
                        reload_pend[i] <= 1'b1;
                    end
                end else if (in_rise && reload_pend[i]) begin
                    count[i] <= reload[i];
                    reload_pend[i] <= 1'b0;
                end
            end

            // Reload value, written by software only
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    reload[i] <= RELOAD_RESET;
                end else if (wr_done && paddr == wr_reload_offset) begin
                    reload[i] <= pwdata[7:0];
                end
            end

            // Interrupt pulse in the same step as the underflow, except channel 0 in 16-bit mode
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    underflow_irq[i] <= 1'b0;
                end else begin
                    underflow_irq[i] <= uf_now[i] && (i == 1 || !ctrl.mode16);
                end
            end
        end
    endgenerate

    // Control register; run bits hold no history, state is in running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ctrl_type'(CTRL_RESET);
        end else if (wr_done && paddr == CTRL_OFFSET) begin
            ctrl <= ctrl_type'(pwdata[7:0]);
        end
    end

    // Output toggles on the effective channel's underflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_toggle <= 1'b0;
        end else if (ctrl.mode16 ? uf_now[1] : uf_now[0]) begin
            out_toggle <= !out_toggle;
        end
    end

    // Gate acts regardless of the toggle phase, so a partial half period can appear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_output_pin_signal <= 1'b0;
            high_speed_oscillator <= 1'b0;
        end else begin
            timer_output_pin_signal <= out_toggle && ctrl.timer_output_gate;
            high_speed_oscillator <= ctrl.hs_osc_enable;
        end
    end

    // Read mux; nibbles are live counter bits, nothing is latched
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (paddr == CTRL_OFFSET) begin
            next_rdata[7:0] = ctrl;
            next_rdata[1:0] = ctrl.chan_run_bit | running;
        end else if (paddr == RELOAD0_OFFSET) begin
            next_rdata[7:0] = reload[0];
        end else if (paddr == RELOAD1_OFFSET) begin
            next_rdata[7:0] = reload[1];
        end else if (paddr == COUNT0_LOW_OFFSET) begin
            next_rdata[3:0] = count[0][3:0];
        end else if (paddr == COUNT0_HIGH_OFFSET) begin
            next_rdata[3:0] = count[0][7:4];
        end else if (paddr == COUNT1_LOW_OFFSET) begin
            next_rdata[3:0] = count[1][3:0];
        end else if (paddr == COUNT1_HIGH_OFFSET) begin
            next_rdata[3:0] = count[1][7:4];
        end else begin
            next_err = 1'b1;
        end
    end

    // APB answer: captured at setup, ready for one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= next_err;
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule
`default_nettype wire
